// ===== hdl/ivlp_regs.svh
// Constants for the interrupt vector and low-power control block
`ifndef IVLP_REGS_SVH
`define IVLP_REGS_SVH
`define IVLP_VEC_RESET      16'hFFFE
`define IVLP_VEC_NMI        16'hFFFC
`define IVLP_VEC_T2_CH0     16'hFFFA
`define IVLP_VEC_T2_REST    16'hFFF8
`define IVLP_VEC_WDT        16'hFFF4
`define IVLP_VEC_T1_CH0     16'hFFF2
`define IVLP_VEC_T1_REST    16'hFFF0
`define IVLP_VEC_SER_RX     16'hFFEE
`define IVLP_VEC_SER_TX     16'hFFEC
`define IVLP_VEC_ADC        16'hFFEA
`define IVLP_VEC_PORT2      16'hFFE6
`define IVLP_VEC_PORT1      16'hFFE4
`define IVLP_VEC_KEY        16'hFFDE
`define IVLP_VEC_TOP        16'hFFFF
`define IVLP_VEC_BASE       16'hFFC0
`define IVLP_VEC_FREE_HI    16'hFFDC
`define IVLP_BLANK_WORD     16'hFFFF
`define IVLP_KEY_NO_BSL     16'hAA55
`define IVLP_KEY_NO_ERASE   16'h0000
`define IVLP_PERIPH_TOP     16'h01FF
`define IVLP_PRIO_RESET     5'h1F
`define IVLP_PRIO_NMI       5'h1E
`define IVLP_ADDR_IE1       8'h00
`define IVLP_ADDR_IFG1      8'h02
`define IVLP_ADDR_STATUS    8'h04
`define IVLP_IE_WDT         0
`define IVLP_IE_OSC         1
`define IVLP_IE_NMI         4
`define IVLP_IE_ACCV        5
`define IVLP_IFG_WDT        0
`define IVLP_IFG_OSC        1
`define IVLP_IFG_POR        2
`define IVLP_IFG_RST        3
`define IVLP_IFG_NMI        4
`define IVLP_IFG1_RESET     8'h06
`endif

// ===== hdl/ivlp_pkg.sv
// Types for the interrupt vector and low-power control block
package ivlp_pkg;
  typedef enum logic [2:0] {
    IVLP_ACTIVE = 3'h0,
    IVLP_LOW_POWER_MODE_ZERO   = 3'h1,
    IVLP_LOW_POWER_MODE_ONE   = 3'h3,
    IVLP_LOW_POWER_MODE_TWO   = 3'h2,
    IVLP_LOW_POWER_MODE_THREE   = 3'h6,
    IVLP_LOW_POWER_MODE_FOUR   = 3'h7
  } ivlp_mode_type;

  typedef enum logic [1:0] {
    IVLP_RUN   = 2'h0,
    IVLP_SAVE  = 2'h1,
    IVLP_FETCH = 2'h3,
    IVLP_HALT  = 2'h2
  } ivlp_state_type;

  // Clock and oscillator gating outputs
  typedef struct packed {
    logic core_run;
    logic aux_clk_en;
    logic main_clk_en;
    logic sub_main_clk_en;
    logic dc_gen_en;
    logic crystal_en;
  } ivlp_clk_type;

  // Maskable peripheral request lines; flags stay in the peripherals
  typedef struct packed {
    logic       t2_ch0;
    logic [1:0] t2_ch12;
    logic       t2_ovf;
    logic       wdt_interval;
    logic       t1_ch0;
    logic [1:0] t1_ch12;
    logic       t1_ovf;
    logic       ser_a_rx;
    logic       ser_b_rx;
    logic       ser_a_tx;
    logic       ser_b_tx;
    logic       adc_done;
    logic [7:0] port2;
    logic [7:0] port1;
  } ivlp_req_type;
endpackage

// ===== hdl/ivlp_prio.sv
// Priority picker for the maskable vectors
`timescale 1ns/1ps
`include "ivlp_regs.svh"
module ivlp_prio
  import ivlp_pkg::*;
(
  // Request lines and global enable
  input  wire ivlp_req_type req,
  input  wire logic         gie,
  // Winner
  output logic              hit,
  output logic [15:0]       vector,
  output logic [4:0]        prio
);
  localparam int N = 10;
  logic [N-1:0] lines;
  logic [15:0]  vec_tab [N];

  // [RULE7] second timer vectors
  assign lines[0] = req.t2_ch0;
  assign lines[1] = |req.t2_ch12 | req.t2_ovf;
  assign lines[2] = req.wdt_interval;
  // [RULE8] first timer vectors
  assign lines[3] = req.t1_ch0;
  assign lines[4] = |req.t1_ch12 | req.t1_ovf;
  // [RULE9] merged receive lines
  assign lines[5] = req.ser_a_rx | req.ser_b_rx;
  // [RULE10] merged transmit lines
  assign lines[6] = req.ser_a_tx | req.ser_b_tx;
  assign lines[7] = req.adc_done;
  // [RULE11] port pin groups
  assign lines[8] = |req.port2;
  assign lines[9] = |req.port1;

  assign vec_tab[0] = `IVLP_VEC_T2_CH0;
  assign vec_tab[1] = `IVLP_VEC_T2_REST;
  assign vec_tab[2] = `IVLP_VEC_WDT;
  assign vec_tab[3] = `IVLP_VEC_T1_CH0;
  assign vec_tab[4] = `IVLP_VEC_T1_REST;
  assign vec_tab[5] = `IVLP_VEC_SER_RX;
  assign vec_tab[6] = `IVLP_VEC_SER_TX;
  assign vec_tab[7] = `IVLP_VEC_ADC;
  assign vec_tab[8] = `IVLP_VEC_PORT2;
  assign vec_tab[9] = `IVLP_VEC_PORT1;

  // Priority number follows the vector word: (addr - base) / 2
  function automatic logic [4:0] prio_of(input logic [15:0] v);
    logic [15:0] d;
    d = v - `IVLP_VEC_BASE;
    return d[5:1];
  endfunction

  // [RULE25] lowest index wins, maskables need global enable
  always_comb begin
    hit    = 1'b0;
    vector = 16'h0000;
    prio   = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (lines[i] && gie) begin
        hit    = 1'b1;
        vector = vec_tab[i];
        prio   = prio_of(vec_tab[i]);
      end
    end
  end
endmodule

// ===== hdl/ivlp_top.sv
// Interrupt and reset vectoring with low-power clock gating
//
// Behaviour
// [RULE1] Vectors and start address sit in words 0xFFFF down to 0xFFC0.
// [RULE2] Blank reset vector after power-up sends the device to mode four.
// [RULE3] All reset causes share vector 0xFFFE at priority 31.
// [RULE4] Pin event, oscillator fault, access violation share 0xFFFC, priority 30.
// [RULE5] Those sources obey own enable, ignore global enable.
// [RULE6] Truly nonmaskable events are taken regardless of any enable.
// [RULE7] Second timer channel 0 at 0xFFFA; rest share 0xFFF8.
// [RULE8] First timer channel 0 at 0xFFF2; rest share 0xFFF0.
// [RULE9] Both serial receive lines share 0xFFEE, priority 23.
// [RULE10] Both serial transmit lines share 0xFFEC, priority 22.
// [RULE11] Port 2 pins to 0xFFE6, port 1 pins to 0xFFE4.
// [RULE12] Words 0xFFDC to 0xFFC0 carry no interrupt source.
// [RULE13] Key word 0xAA55 at 0xFFDE disables the boot loader.
// [RULE14] Key word zero stops flash erase on a bad password.
// [RULE15] Fetch from 0x0000-0x01FF or unused space raises reset.
// [RULE16] Enabled interrupt wakes any low-power mode, mode returns after handler.
// [RULE17] Active mode runs auxiliary, main and sub-main clocks.
// [RULE18] Modes 0 and 1 stop core and main clock; mode 1 may stop generator.
// [RULE19] Mode 2 stops core, main and sub-main; generator stays on.
// [RULE20] Mode 3 stops core, main and sub-main; generator off.
// [RULE21] Mode 4 stops everything including the crystal.
// [RULE22] Peripheral flags stay in peripherals; only request lines come in.
// [RULE23] Power-on flag set on power-up; pin reset flag set by pin, cleared at power-up.
// [RULE24] Enable bits at byte 0x00, cleared by power-up clear.
// [RULE25] Highest priority enabled request wins; maskables need global enable.
// [RULE26] Grant saves context, clears low-power bits, then loads vector.
`timescale 1ns/1ps
`include "ivlp_regs.svh"
module ivlp_top
  import ivlp_pkg::*;
(
  // Clock and reset
  input  wire  logic          core_clk,
  input  wire  logic          reset_n,
  // Reset causes
  input  wire  logic          power_up,
  input  wire  logic          pin_reset,
  input  wire  logic          watchdog_expire,
  input  wire  logic          flash_key_violation,
  // Non-maskable class
  input  wire  logic          pin_nonmaskable_event,
  input  wire  logic          oscillator_fault,
  input  wire  logic          flash_access_violation_flag,
  input  wire  logic          true_nmi,
  // Peripheral request lines
  input  wire  ivlp_req_type  req,
  // Core status and fetch
  input  wire  logic          gie,
  input  wire  logic          lpm_request,
  input  wire  logic [2:0]    lpm_select,
  input  wire  logic          dco_used_active,
  input  wire  logic          handler_return,
  input  wire  logic          fetch_valid,
  input  wire  logic [15:0]   fetch_addr,
  input  wire  logic          fetch_mapped,
  // Vector memory word reads
  input  wire  logic [15:0]   reset_vector_word,
  input  wire  logic [15:0]   boot_loader_key_word,
  // Register port
  input  wire  logic [7:0]    reg_addr,
  input  wire  logic [7:0]    reg_wdata,
  input  wire  logic          reg_wr,
  input  wire  logic          reg_rd,
  output logic [7:0]          reg_rdata,
  // To the core
  output logic                core_reset,
  output logic                save_context,
  output logic                load_vector,
  output logic [15:0]         vector_addr,
  output logic [4:0]          grant_prio,
  output ivlp_clk_type        clk_ctl,
  output logic                boot_loader_enable,
  output logic                bad_password_erase_en
);
  ///////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) rst_sync_reg <= 2'h0;
    else          rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  ///////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] ie_reg;
  logic [7:0] ifg_reg;
  logic [7:0] ifg_next;
  logic       wr_ie;
  logic       wr_ifg;
  logic [7:0] ie_mask;
  logic [7:0] ifg_mask;
  assign wr_ie    = reg_wr && reg_addr == `IVLP_ADDR_IE1;
  assign wr_ifg   = reg_wr && reg_addr == `IVLP_ADDR_IFG1;
  assign ie_mask  = 8'h33;
  assign ifg_mask = 8'h1F;

  // [RULE24] enable bits, cleared at power-up clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)            ie_reg <= 8'h00;
    else if (core_reset)   ie_reg <= 8'h00;
    else if (wr_ie)        ie_reg <= reg_wdata & ie_mask;
  end

  // [RULE23] set wins over a software clear
  always_comb begin
    ifg_next = wr_ifg ? (reg_wdata & ifg_mask) : ifg_reg;
    if (power_up) begin
      ifg_next[`IVLP_IFG_POR] = 1'b1;
      ifg_next[`IVLP_IFG_RST] = 1'b0;
    end
    if (pin_reset)             ifg_next[`IVLP_IFG_RST] = 1'b1;
    if (watchdog_expire || flash_key_violation) ifg_next[`IVLP_IFG_WDT] = 1'b1;
    if (oscillator_fault)      ifg_next[`IVLP_IFG_OSC] = 1'b1;
    if (pin_nonmaskable_event) ifg_next[`IVLP_IFG_NMI] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) ifg_reg <= `IVLP_IFG1_RESET;
    else        ifg_reg <= ifg_next;
  end

  ///////////////////////////////////////////////////////////////////////////
  // Reset sources
  logic fetch_bad;
  logic reset_cause;
  // [RULE15] fetch from peripheral space or unmapped space
  assign fetch_bad   = fetch_valid && (fetch_addr <= `IVLP_PERIPH_TOP || !fetch_mapped);
  // [RULE3] one reset vector for all causes
  assign reset_cause = power_up | pin_reset | watchdog_expire | flash_key_violation
                     | fetch_bad;

  ///////////////////////////////////////////////////////////////////////////
  // Request selection
  logic       nmi_hit;
  logic       mask_hit;
  logic [15:0] mask_vec;
  logic [4:0]  mask_prio;
  logic        any_hit;

  // [RULE4] shared non-maskable vector
  // [RULE5] own enables gate, global enable ignored
  // [RULE6] true nonmaskable bypasses all enables
  assign nmi_hit = (ifg_reg[`IVLP_IFG_NMI] & ie_reg[`IVLP_IE_NMI])
                 | (ifg_reg[`IVLP_IFG_OSC] & ie_reg[`IVLP_IE_OSC])
                 | (flash_access_violation_flag & ie_reg[`IVLP_IE_ACCV])
                 | true_nmi;

  // [RULE22] maskable requests are bare lines, no local flag copy
  ivlp_prio u_prio (
    .req    (req),
    .gie    (gie),
    .hit    (mask_hit),
    .vector (mask_vec),
    .prio   (mask_prio)
  );
  assign any_hit = nmi_hit | mask_hit;

  ///////////////////////////////////////////////////////////////////////////
  // Grant sequencer and mode
  ivlp_state_type state_reg;
  ivlp_state_type state_next;
  ivlp_mode_type  mode_reg;
  ivlp_mode_type  mode_next;
  ivlp_mode_type  saved_mode_reg;
  logic [15:0]    vec_reg;
  logic [4:0]     prio_reg;
  logic           blank_vec;
  logic           boot_seen_reg;

  // [RULE2] blank reset vector read at start
  assign blank_vec = reset_vector_word == `IVLP_BLANK_WORD;

  function automatic ivlp_mode_type mode_of(input logic [2:0] s);
    case (s)
      3'h0:    return IVLP_LOW_POWER_MODE_ZERO;
      3'h1:    return IVLP_LOW_POWER_MODE_ONE;
      3'h2:    return IVLP_LOW_POWER_MODE_TWO;
      3'h3:    return IVLP_LOW_POWER_MODE_THREE;
      default: return IVLP_LOW_POWER_MODE_FOUR;
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    case (state_reg)
      IVLP_RUN: begin
        // [RULE16] any granted request wakes the core
        if (any_hit) state_next = IVLP_SAVE;
        else if (lpm_request) mode_next = mode_of(lpm_select);
        else if (handler_return) mode_next = saved_mode_reg;
      end
      IVLP_SAVE: begin
        // [RULE26] clocks restart in the same cycle as the vector load
        mode_next  = IVLP_ACTIVE;
        state_next = IVLP_FETCH;
      end
      IVLP_FETCH: state_next = IVLP_RUN;
      IVLP_HALT: begin
        if (any_hit) state_next = IVLP_SAVE;
      end
      default: state_next = IVLP_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= IVLP_RUN;
      mode_reg       <= IVLP_ACTIVE;
      saved_mode_reg <= IVLP_ACTIVE;
      vec_reg        <= `IVLP_VEC_RESET;
      prio_reg       <= `IVLP_PRIO_RESET;
      boot_seen_reg  <= 1'b0;
    end else if (reset_cause) begin
      // [RULE3] reset outranks every interrupt
      state_reg      <= IVLP_FETCH;
      mode_reg       <= IVLP_ACTIVE;
      saved_mode_reg <= IVLP_ACTIVE;
      vec_reg        <= `IVLP_VEC_RESET;
      prio_reg       <= `IVLP_PRIO_RESET;
      boot_seen_reg  <= power_up;
    end else begin
      boot_seen_reg <= 1'b0;
      if (boot_seen_reg && blank_vec) begin
        // [RULE2] no execution, deepest mode
        state_reg <= IVLP_HALT;
        mode_reg  <= IVLP_LOW_POWER_MODE_FOUR;
      end else begin
        state_reg <= state_next;
        mode_reg  <= mode_next;
      end
      if (state_next == IVLP_SAVE && state_reg != IVLP_SAVE) begin
        saved_mode_reg <= mode_reg;
        // [RULE25] non-maskable class outranks all maskables
        vec_reg  <= nmi_hit ? `IVLP_VEC_NMI : mask_vec;
        prio_reg <= nmi_hit ? `IVLP_PRIO_NMI : mask_prio;
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Clock gating per mode
  ivlp_clk_type clk_next;
  always_comb begin
    clk_next = '{default: 1'b1};
    case (mode_reg)
      // [RULE17] all clocks run
      IVLP_ACTIVE: clk_next = '{default: 1'b1};
      // [RULE18] core and main clock halted
      IVLP_LOW_POWER_MODE_ZERO: begin
        clk_next.core_run    = 1'b0;
        clk_next.main_clk_en = 1'b0;
      end
      IVLP_LOW_POWER_MODE_ONE: begin
        clk_next.core_run    = 1'b0;
        clk_next.main_clk_en = 1'b0;
        clk_next.dc_gen_en   = dco_used_active;
      end
      // [RULE19] generator stays on
      IVLP_LOW_POWER_MODE_TWO: begin
        clk_next.core_run        = 1'b0;
        clk_next.main_clk_en     = 1'b0;
        clk_next.sub_main_clk_en = 1'b0;
      end
      // [RULE20] generator off
      IVLP_LOW_POWER_MODE_THREE: begin
        clk_next.core_run        = 1'b0;
        clk_next.main_clk_en     = 1'b0;
        clk_next.sub_main_clk_en = 1'b0;
        clk_next.dc_gen_en       = 1'b0;
      end
      // [RULE21] everything stopped
      IVLP_LOW_POWER_MODE_FOUR: clk_next = '{default: 1'b0};
      default:   clk_next = '{default: 1'b1};
    endcase
  end

  ///////////////////////////////////////////////////////////////////////////
  // Output flops
  logic [7:0] rdata_next;
  assign rdata_next = !reg_rd                          ? 8'h00 :
                      reg_addr == `IVLP_ADDR_IE1       ? ie_reg :
                      reg_addr == `IVLP_ADDR_IFG1      ? ifg_reg :
                      reg_addr == `IVLP_ADDR_STATUS    ? {3'h0, state_reg, mode_reg} :
                      8'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata             <= 8'h00;
      core_reset            <= 1'b1;
      save_context          <= 1'b0;
      load_vector           <= 1'b0;
      vector_addr           <= `IVLP_VEC_RESET;
      grant_prio            <= `IVLP_PRIO_RESET;
      clk_ctl               <= '{default: 1'b1};
      boot_loader_enable    <= 1'b0;
      bad_password_erase_en <= 1'b1;
    end else begin
      reg_rdata    <= rdata_next;
      core_reset   <= reset_cause;
      save_context <= state_reg == IVLP_SAVE;
      // [RULE1] vector words all lie in the top block
      // [RULE12] low words never selected as vectors
      load_vector  <= state_reg == IVLP_FETCH;
      vector_addr  <= vec_reg;
      grant_prio   <= prio_reg;
      clk_ctl      <= clk_next;
      // [RULE13] key word disables boot loader
      boot_loader_enable    <= boot_loader_key_word != `IVLP_KEY_NO_BSL;
      // [RULE14] zero key inhibits erase
      bad_password_erase_en <= boot_loader_key_word != `IVLP_KEY_NO_ERASE;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_vector: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
    reset_cause |=> ##1 (load_vector && vector_addr == `IVLP_VEC_RESET))
    else $error("reset not vectored to top word");
  a_nmi_vector: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE4]
    (state_reg == IVLP_SAVE && vec_reg == `IVLP_VEC_NMI && !reset_cause)
      |=> ##1 grant_prio == 5'h1E)
    else $error("nmi priority wrong");
  a_blank_halt: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE2]
    (boot_seen_reg && blank_vec && !reset_cause) |=> ##1 clk_ctl == '0)
    else $error("blank vector did not halt");
  a_true_nmi: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE6]
    (true_nmi && state_reg == IVLP_RUN && !reset_cause) |=> state_reg == IVLP_SAVE)
    else $error("true nmi ignored");
  a_gie_mask: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE25]
    (!gie && !nmi_hit && state_reg == IVLP_RUN && !reset_cause) |=> state_reg != IVLP_SAVE)
    else $error("maskable taken without global enable");
  a_wake_active: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE26]
    (state_reg == IVLP_SAVE && !reset_cause) |=> ##1 clk_ctl.main_clk_en)
    else $error("clocks not restarted");
  a_bad_fetch: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE15]
    (fetch_valid && fetch_addr <= 16'h01FF) |=> core_reset)
    else $error("bad fetch missed");
  a_low_power_mode_three_gate: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE20]
    mode_reg == IVLP_LOW_POWER_MODE_THREE |=> (!clk_ctl.dc_gen_en && clk_ctl.aux_clk_en))
    else $error("mode three gating wrong");
  c_wake: cover property (@(posedge core_clk) disable iff (!rst_n)
    mode_reg == IVLP_LOW_POWER_MODE_THREE ##1 state_reg == IVLP_SAVE);
  c_return: cover property (@(posedge core_clk) disable iff (!rst_n)
    handler_return && saved_mode_reg != IVLP_ACTIVE);
  c_nmi: cover property (@(posedge core_clk) disable iff (!rst_n)
    nmi_hit && mask_hit);
endmodule

// ===== verif/ivlp_core_model.sv
// Processor core model: runs a handler after each vector load other than 0xFFFE, then returns
`timescale 1ns/1ps
module ivlp_core_model #(
  parameter int RET_DELAY = 4
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Vector entry from the block
  input  wire logic        load_vector,
  input  wire logic [15:0] vector_addr,
  // Return from handler
  output logic             handler_return
);
  int count_reg;

  // handler ends in a return
  // Reset entry never returns, there is no context to restore
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg      <= 0;
      handler_return <= 1'b0;
    end else begin
      handler_return <= (count_reg == 1);
      if (load_vector && vector_addr != 16'hFFFE) begin
        count_reg <= RET_DELAY;
      end else if (count_reg != 0) begin
        count_reg <= count_reg - 1;
      end
    end
  end
endmodule

// ===== verif/test_ivlp_top.sv
// Self-checking bench for the interrupt vector and low-power control block
`timescale 1ns/1ps
`define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", name, exp, got); end end
module test_ivlp_top
  import ivlp_pkg::*;
;
  logic         core_clk, reset_n, fetch_valid, power_up, pin_reset, watchdog_expire;
  logic         flash_key_violation, flash_access_violation_flag, true_nmi, gie;
  logic         lpm_request, dco_used_active, handler_return, fetch_mapped;
  logic         reg_wr, reg_rd, core_reset, save_context, load_vector;
  logic         boot_loader_enable, bad_password_erase_en;
  logic         pin_nonmaskable_event, oscillator_fault;
  logic [2:0]   lpm_select;
  logic [4:0]   cause, grant_prio;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  logic [15:0]  fetch_addr, reset_vector_word, boot_loader_key_word, vector_addr;
  ivlp_req_type req;
  ivlp_clk_type clk_ctl;
  int           mismatches, comparisons, i;
  logic [15:0]  vec_tab [0:13] = '{16'hFFFA, 16'hFFF8, 16'hFFF8, 16'hFFF4, 16'hFFF2,
    16'hFFF0, 16'hFFF0, 16'hFFEE, 16'hFFEE, 16'hFFEC, 16'hFFEC, 16'hFFEA, 16'hFFE6, 16'hFFE4};
  logic [2:0]   sel_tab [0:5] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [5:0]   clk_tab [0:5] = '{6'h17, 6'h15, 6'h17, 6'h13, 6'h11, 6'h00};
  logic [5:0]   dco_tab = 6'b000100;

  assign {fetch_valid, power_up, pin_reset, watchdog_expire, flash_key_violation} = cause;

  ivlp_top ivlp_top_i (.core_clk, .reset_n, .power_up, .pin_reset, .watchdog_expire,
    .flash_key_violation, .pin_nonmaskable_event, .oscillator_fault,
    .flash_access_violation_flag, .true_nmi, .req, .gie, .lpm_request, .lpm_select,
    .dco_used_active, .handler_return, .fetch_valid, .fetch_addr, .fetch_mapped,
    .reset_vector_word, .boot_loader_key_word, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .core_reset, .save_context, .load_vector, .vector_addr, .grant_prio,
    .clk_ctl, .boot_loader_enable, .bad_password_erase_en);

  ivlp_core_model #(.RET_DELAY(4)) ivlp_core_model_i (.core_clk, .reset_n, .load_vector,
    .vector_addr, .handler_return);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task test_done();
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task hw_reset();
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge core_clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata & m)
  endtask

  // The peripheral drops its line at vector entry, so a held level cannot regrant
  task take(input logic [15:0] v);
    int n;
    n = 0;
    while (save_context !== 1'b1 && n < 30) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    @(posedge core_clk);
    req                         <= '0;
    flash_access_violation_flag <= 1'b0;
    true_nmi                    <= 1'b0;
    oscillator_fault            <= 1'b0;
    #1;
    `CHK("load_vector", 1'b1, load_vector)
    `CHK("vector_addr", v, vector_addr)
    `CHK("grant_prio", 5'((v - 16'hFFC0) >> 1), grant_prio)
  endtask

  task quiet(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
      `CHK("load_vector", 1'b0, load_vector)
    end
  endtask

  task rst_cause(input logic [4:0] c, input logic e);
    int n;
    n = 0;
    @(posedge core_clk);
    cause <= c;
    #1;
    while (core_reset !== 1'b1 && n < 6) begin
      @(posedge core_clk);
      cause <= '0;
      #1;
      n++;
    end
    `CHK("core_reset", e, core_reset)
    if (e) begin
      @(posedge core_clk);
      #1;
      `CHK("load_vector", 1'b1, load_vector)
      `CHK("vector_addr", 16'hFFFE, vector_addr)
      `CHK("grant_prio", 5'h1F, grant_prio)
    end
  endtask

  task fetch(input logic [15:0] a, input logic m, input logic e);
    @(posedge core_clk);
    fetch_addr   <= a;
    fetch_mapped <= m;
    rst_cause(5'h10, e);
  endtask

  task boot(input logic [15:0] k, input logic en, input logic er);
    @(posedge core_clk);
    boot_loader_key_word <= k;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("boot_loader_enable", en, boot_loader_enable)
    `CHK("bad_password_erase_en", er, bad_password_erase_en)
  endtask

  function automatic ivlp_req_type mk(input int k);
    ivlp_req_type r;
    r = '0;
    case (k)
      0: r.t2_ch0 = 1'b1;
      1: r.t2_ch12[1] = 1'b1;
      2: r.t2_ovf = 1'b1;
      3: r.wdt_interval = 1'b1;
      4: r.t1_ch0 = 1'b1;
      5: r.t1_ch12[0] = 1'b1;
      6: r.t1_ovf = 1'b1;
      7: r.ser_a_rx = 1'b1;
      8: r.ser_b_rx = 1'b1;
      9: r.ser_a_tx = 1'b1;
      10: r.ser_b_tx = 1'b1;
      11: r.adc_done = 1'b1;
      12: r.port2[7] = 1'b1;
      default: r.port1[0] = 1'b1;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, cause, flash_access_violation_flag, true_nmi, gie, lpm_request} = '0;
    {lpm_select, dco_used_active, fetch_mapped, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {req, fetch_addr, pin_nonmaskable_event, oscillator_fault} = '0;
    reset_vector_word    = 16'h4000;
    boot_loader_key_word = 16'h1234;
    hw_reset();
    wr(8'h02, 8'h00);
    rst_cause(5'h08, 1'b1);
    rd(8'h02, 8'h0C, 8'h04);
    rst_cause(5'h04, 1'b1);
    rd(8'h02, 8'h0C, 8'h0C);
    rst_cause(5'h08, 1'b1);
    rd(8'h02, 8'h0C, 8'h04);
    wr(8'h02, 8'h00);
    rst_cause(5'h01, 1'b1);
    rd(8'h02, 8'h01, 8'h01);
    rst_cause(5'h02, 1'b1);
    fetch(16'h01FF, 1'b1, 1'b1);
    fetch(16'h0200, 1'b1, 1'b0);
    fetch(16'hC000, 1'b0, 1'b1);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hFF, 8'h33);
    rd(8'h10, 8'hFF, 8'h00);
    rst_cause(5'h04, 1'b1);
    rd(8'h00, 8'hFF, 8'h00);
    wr(8'h00, 8'h01);
    gie <= 1'b1;
    for (i = 0; i < 14; i++) begin
      @(posedge core_clk);
      req <= mk(i);
      take(vec_tab[i]);
      quiet(6);
    end
    @(posedge core_clk);
    req <= ivlp_req_type'(mk(0) | mk(4));
    take(16'hFFFA);
    wr(8'h00, 8'h20);
    @(posedge core_clk);
    flash_access_violation_flag <= 1'b1;
    req <= mk(13);
    take(16'hFFFC);
    gie <= 1'b0;
    @(posedge core_clk);
    req <= mk(13);
    quiet(10);
    @(posedge core_clk);
    gie <= 1'b1;
    take(16'hFFE4);
    gie <= 1'b0;
    wr(8'h00, 8'h00);
    @(posedge core_clk);
    flash_access_violation_flag <= 1'b1;
    quiet(10);
    wr(8'h00, 8'h20);
    take(16'hFFFC);
    wr(8'h00, 8'h00);
    @(posedge core_clk);
    true_nmi <= 1'b1;
    take(16'hFFFC);
    wr(8'h02, 8'h00);
    wr(8'h00, 8'h12);
    @(posedge core_clk);
    oscillator_fault <= 1'b1;
    take(16'hFFFC);
    wr(8'h00, 8'h00);
    @(posedge core_clk);
    pin_nonmaskable_event <= 1'b1;
    quiet(4);
    rd(8'h02, 8'h12, 8'h12);
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h12, 8'h10);
    pin_nonmaskable_event <= 1'b0;
    boot(16'hAA55, 1'b0, 1'b1);
    boot(16'h0000, 1'b1, 1'b0);
    boot(16'h1234, 1'b1, 1'b1);
    gie <= 1'b1;
    for (i = 0; i < 6; i++) begin
      hw_reset();
      #1;
      `CHK("clk_ctl", 6'h3F, clk_ctl)
      @(posedge core_clk);
      lpm_request     <= 1'b1;
      lpm_select      <= sel_tab[i];
      dco_used_active <= dco_tab[i];
      @(posedge core_clk);
      lpm_request <= 1'b0;
      @(posedge core_clk);
      #1;
      `CHK("clk_ctl", clk_tab[i], clk_ctl)
      @(posedge core_clk);
      req.port1[3] <= 1'b1;
      take(16'hFFE4);
      `CHK("clk_ctl", 6'h3F, clk_ctl)
      repeat (8) @(posedge core_clk);
      #1;
      `CHK("clk_ctl", clk_tab[i], clk_ctl)
    end
    @(posedge core_clk);
    reset_vector_word <= 16'hFFFF;
    cause             <= 5'h08;
    @(posedge core_clk);
    cause <= '0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("clk_ctl", 6'h00, clk_ctl)
    test_done();
  end

  initial begin
    #300us;
    mismatches++;
    test_done();
  end
endmodule
